//--- include/uart_lfmc_map.vh
`ifndef UART_LFMC_MAP_VH
`define UART_LFMC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_DATA 4'h0
`define A_DIVH 4'h1
`define A_FIFO 4'h2
`define A_LINE 4'h3
`define A_MODEM 4'h4
`define A_LSTAT 4'h5
`define A_MSTAT 4'h6
`define A_EFR 4'h8
`define A_XON 4'h9
`define A_XOFF 4'hA
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LINE_RST 8'h00
`define MODEM_RST 8'h00
`define EFR_RST 8'h00
`define XON_RST 8'h11
`define XOFF_RST 8'h13
`define DIV_RST 16'h0001
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LC_STOP 2
`define LC_PEN 3
`define LC_EVEN 4
`define LC_FORCE 5
`define LC_BRK 6
`define LC_DLAB 7
`define MC_DTR 0
`define MC_RTS 1
`define MC_IRPOL 2
`define MC_OUT2 3
`define MC_LOOP 4
`define MC_XANY 5
`define MC_IR 6
`define EF_SWFC 1
`define EF_EN 4
`define EF_ARTS 6
`define FC_EN 0
`define FC_RXRST 1
`define FC_TXRST 2
// ----------------------------------------
// Trigger levels and timing counts
// ----------------------------------------
`define RXT_0 6'h08
`define RXT_1 6'h10
`define RXT_2 6'h18
`define RXT_3 6'h1C
`define TXT_0 6'h10
`define TXT_1 6'h08
`define TXT_2 6'h18
`define TXT_3 6'h1E
`define FIFO_CAP 6'h20
`define BIT_TICKS 6'h10
`define HALF_TICKS 6'h08
`define STOP_15 6'h18
`define STOP_2 6'h20
`endif

//--- rtl/uart_line_format_modem_control.v
`include "uart_lfmc_map.vh"
`default_nettype none

module uart_line_format_modem_control (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata_q,
  input wire rx_pin,
  input wire cts_n,
  input wire dsr_n,
  input wire cd_n,
  input wire ring_indicator_n,
  output reg tx_pin_q,
  output reg rts_n_q,
  output reg dtr_n_q,
  output reg general_out_two_n_q,
  output reg int_out_q,
  output reg int_oe_n_q
);

  localparam [4:0] T_IDLE = 5'b0_0001;
  localparam [4:0] T_START = 5'b0_0010;
  localparam [4:0] T_DATA = 5'b0_0100;
  localparam [4:0] T_PAR = 5'b0_1000;
  localparam [4:0] T_STOP = 5'b1_0000;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Parity bit for the character under the current format
  function par_calc;
    input [7:0] d;
    input [7:0] lc;
    reg [7:0] m;
    begin
      m = d & (8'hFF >> (3'h3 - {1'b0, lc[1:0]}));
      par_calc = lc[`LC_EVEN] ? ^m : ~^m;
      if (lc[`LC_FORCE]) begin
        par_calc = ~lc[`LC_EVEN];
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [4:0] meta_q, sync_q;
  reg [7:0] line_q, modem_q, efr_q, xon_q, xoff_q;
  reg [15:0] div_q, bcnt_q;
  reg fen_q, tick_q, halt_q;
  reg [1:0] rxtrig_q, txtrig_q;
  reg [7:0] txm [0:31];
  reg [8:0] rxm [0:31];
  reg [4:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  reg [5:0] tx_cnt_q, rx_cnt_q;
  reg [4:0] ts_q, rs_q;
  reg [7:0] tsh_q, rsh_q;
  reg [2:0] tbit_q, rbit_q;
  reg [5:0] ttk_q, rtk_q;
  reg tser_q, tpar_q, rpar_q;
  reg tx_above_q, tx_irq_q, tx_pop_q;
  reg [7:0] rd_mux;

  wire dlab = line_q[`LC_DLAB];
  wire ef_en = efr_q[`EF_EN];
  wire loop = modem_q[`MC_LOOP];
  wire ir_mode = modem_q[`MC_IR] & ef_en;
  wire [2:0] len_m1 = {1'b1, line_q[1:0]};
  wire [5:0] cap = fen_q ? `FIFO_CAP : 6'h01;
  wire tx_full = tx_cnt_q >= cap;
  wire rx_full = rx_cnt_q >= cap;
  wire tx_idle = ts_q == T_IDLE;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Order: ring, cd, dsr, cts, rx
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 5'h1F;
      sync_q <= 5'h1F;
    end else begin
      meta_q <= {ring_indicator_n, cd_n, dsr_n, cts_n, rx_pin};
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  wire wr_fifo = wr_en && addr == `A_FIFO && wdata[`FC_EN];
  wire tx_rst = wr_fifo && wdata[`FC_TXRST];
  wire rx_rst = wr_fifo && wdata[`FC_RXRST];
  // data registers only when divisor access is off
  wire tx_push = wr_en && addr == `A_DATA && !dlab && !tx_full;
  wire rx_pop = rd_en && addr == `A_DATA && !dlab && rx_cnt_q != 6'h00;

  // Configuration registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= `LINE_RST;
      modem_q <= `MODEM_RST;
      efr_q <= `EFR_RST;
      xon_q <= `XON_RST;
      xoff_q <= `XOFF_RST;
      div_q <= `DIV_RST;
      fen_q <= 1'b0;
      rxtrig_q <= 2'b00;
      txtrig_q <= 2'b00;
    end else if (wr_en) begin
      case (addr)
        `A_DATA: if (dlab) div_q[7:0] <= wdata;
        `A_DIVH: if (dlab) div_q[15:8] <= wdata;
        `A_FIFO: begin
          fen_q <= wdata[`FC_EN];
          if (wdata[`FC_EN]) begin
            rxtrig_q <= wdata[7:6];
            if (ef_en) txtrig_q <= wdata[5:4];
          end
        end
        `A_LINE: line_q <= wdata;
        `A_MODEM: modem_q <= wdata;
        `A_EFR: efr_q <= wdata;
        `A_XON: xon_q <= wdata;
        `A_XOFF: xoff_q <= wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Trigger levels
  // ----------------------------------------
  reg [5:0] rx_thr, tx_thr;
  always @* begin
    case (rxtrig_q)
      2'b00: rx_thr = `RXT_0;
      2'b01: rx_thr = `RXT_1;
      2'b10: rx_thr = `RXT_2;
      default: rx_thr = `RXT_3;
    endcase
    case (txtrig_q)
      2'b00: tx_thr = `TXT_0;
      2'b01: tx_thr = `TXT_1;
      2'b10: tx_thr = `TXT_2;
      default: tx_thr = `TXT_3;
    endcase
    // Without FIFOs a single holding slot acts as the level
    if (!fen_q) begin
      rx_thr = 6'h01;
      tx_thr = 6'h01;
    end
  end

  // ----------------------------------------
  // Baud tick (16 per bit)
  // ----------------------------------------
  // A zero divisor runs as one, never stalls the link
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (bcnt_q == 16'h0000) begin
      bcnt_q <= (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
      tick_q <= 1'b1;
    end else begin
      bcnt_q <= bcnt_q - 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  wire tx_load = tx_idle && tx_cnt_q != 6'h00 && !halt_q;
  always @(posedge mclk) begin
    if (tx_push) txm[tx_wp_q] <= wdata;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_q <= 5'h00;
      tx_rp_q <= 5'h00;
      tx_cnt_q <= 6'h00;
    end else if (tx_rst) begin
      tx_wp_q <= 5'h00;
      tx_rp_q <= 5'h00;
      tx_cnt_q <= 6'h00;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 5'h01;
      if (tx_load) tx_rp_q <= tx_rp_q + 5'h01;
      tx_cnt_q <= tx_cnt_q + {5'h00, tx_push} - {5'h00, tx_load};
    end
  end

  // ----------------------------------------
  // Transmit interrupt
  // ----------------------------------------
  // Set beats the clear from a same-cycle write
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_above_q <= 1'b0;
      tx_irq_q <= 1'b0;
      tx_pop_q <= 1'b0;
    end else begin
      tx_pop_q <= tx_load;
      if (tx_above_q && tx_cnt_q < tx_thr) begin
        tx_irq_q <= 1'b1;
        tx_above_q <= 1'b0;
      end else if (!tx_above_q && tx_pop_q && tx_cnt_q == 6'h00) begin
        tx_irq_q <= 1'b1;
      end else if (tx_push) begin
        tx_irq_q <= 1'b0;
      end
      if (tx_cnt_q > tx_thr) tx_above_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire t_end_bit = tick_q && ttk_q == `BIT_TICKS - 6'h01;
  reg [5:0] stop_len;
  always @* begin
    if (!line_q[`LC_STOP]) stop_len = `BIT_TICKS;
    else if (line_q[1:0] == 2'b00) stop_len = `STOP_15;
    else stop_len = `STOP_2;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ts_q <= T_IDLE;
      tsh_q <= 8'h00;
      tbit_q <= 3'h0;
      ttk_q <= 6'h00;
      tser_q <= 1'b1;
      tpar_q <= 1'b0;
    end else begin
      if (tick_q) ttk_q <= ttk_q + 6'h01;
      case (ts_q)
        T_IDLE: begin
          tser_q <= 1'b1;
          if (tx_load) begin
            tsh_q <= txm[tx_rp_q];
            tpar_q <= par_calc(txm[tx_rp_q], line_q);
            tser_q <= 1'b0;
            ttk_q <= 6'h00;
            ts_q <= T_START;
          end
        end
        T_START: if (t_end_bit) begin
          ttk_q <= 6'h00;
          tbit_q <= 3'h0;
          tser_q <= tsh_q[0];
          ts_q <= T_DATA;
        end
        T_DATA: if (t_end_bit) begin
          ttk_q <= 6'h00;
          if (tbit_q == len_m1) begin
            ts_q <= line_q[`LC_PEN] ? T_PAR : T_STOP;
            tser_q <= line_q[`LC_PEN] ? tpar_q : 1'b1;
          end else begin
            tbit_q <= tbit_q + 3'h1;
            tsh_q <= {1'b0, tsh_q[7:1]};
            tser_q <= tsh_q[1];
          end
        end
        T_PAR: if (t_end_bit) begin
          ttk_q <= 6'h00;
          tser_q <= 1'b1;
          ts_q <= T_STOP;
        end
        T_STOP: if (tick_q && ttk_q == stop_len - 6'h01) begin
          ttk_q <= 6'h00;
          ts_q <= T_IDLE;
        end
        default: ts_q <= T_IDLE;
      endcase
    end
  end

  wire serial_out = line_q[`LC_BRK] ? 1'b0 : tser_q;

  // ----------------------------------------
  // Receive line selection
  // ----------------------------------------
  // infrared receive polarity
  wire rx_dec = ir_mode ? (modem_q[`MC_IRPOL] ? sync_q[0] : ~sync_q[0]) : sync_q[0];
  wire rx_line = loop ? serial_out : rx_dec;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg done_q;
  wire r_mid = tick_q && rtk_q == `BIT_TICKS - 6'h01;
  wire [7:0] rx_char = rsh_q >> (3'h7 - len_m1);
  wire rx_perr = line_q[`LC_PEN] && rpar_q != par_calc(rx_char, line_q);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q <= T_IDLE;
      rsh_q <= 8'h00;
      rbit_q <= 3'h0;
      rtk_q <= 6'h00;
      rpar_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tick_q) rtk_q <= rtk_q + 6'h01;
      case (rs_q)
        T_IDLE: if (!rx_line) begin
          rtk_q <= 6'h00;
          rs_q <= T_START;
        end
        // Mid start check rejects glitches shorter than half a bit
        T_START: if (tick_q && rtk_q == `HALF_TICKS - 6'h01) begin
          rtk_q <= 6'h00;
          rbit_q <= 3'h0;
          rs_q <= rx_line ? T_IDLE : T_DATA;
        end
        T_DATA: if (r_mid) begin
          rtk_q <= 6'h00;
          rsh_q <= {rx_line, rsh_q[7:1]};
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == len_m1) rs_q <= line_q[`LC_PEN] ? T_PAR : T_STOP;
        end
        T_PAR: if (r_mid) begin
          rtk_q <= 6'h00;
          rpar_q <= rx_line;
          rs_q <= T_STOP;
        end
        T_STOP: if (r_mid) begin
          done_q <= 1'b1;
          rs_q <= T_IDLE;
        end
        default: rs_q <= T_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Software flow control
  // ----------------------------------------
  wire sw_fc = efr_q[`EF_SWFC];
  wire is_xon = sw_fc && rx_char == xon_q;
  wire is_xoff = sw_fc && rx_char == xoff_q;
  wire xany = modem_q[`MC_XANY] && ef_en;
  wire rx_push = done_q && !(is_xon || is_xoff) && !rx_full;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halt_q <= 1'b0;
    end else if (!sw_fc) begin
      halt_q <= 1'b0;
    end else if (done_q) begin
      if (is_xoff) halt_q <= 1'b1;
      else if (is_xon || xany) halt_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rx_push) rxm[rx_wp_q] <= {rx_perr, rx_char};
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_q <= 5'h00;
      rx_rp_q <= 5'h00;
      rx_cnt_q <= 6'h00;
    end else if (rx_rst) begin
      rx_wp_q <= 5'h00;
      rx_rp_q <= 5'h00;
      rx_cnt_q <= 6'h00;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + 5'h01;
      if (rx_pop) rx_rp_q <= rx_rp_q + 5'h01;
      rx_cnt_q <= rx_cnt_q + {5'h00, rx_push} - {5'h00, rx_pop};
    end
  end

  wire rx_irq = rx_cnt_q >= rx_thr;
  wire rx_any = rx_cnt_q != 6'h00;
  wire [8:0] rx_head = rx_any ? rxm[rx_rp_q] : 9'h000;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Loopback status mirrors the modem outputs
  wire [3:0] mstat = loop ? {modem_q[`MC_OUT2], modem_q[`MC_IRPOL],
                             modem_q[`MC_DTR], modem_q[`MC_RTS]}
                          : ~{sync_q[3], sync_q[4], sync_q[2], sync_q[1]};
  always @* begin
    case (addr)
      `A_DATA: rd_mux = dlab ? div_q[7:0] : rx_head[7:0];
      `A_DIVH: rd_mux = dlab ? div_q[15:8] : 8'h00;
      `A_FIFO: rd_mux = {fen_q, fen_q, 2'b00, halt_q, 1'b0, tx_irq_q, rx_irq};
      `A_LINE: rd_mux = line_q;
      `A_MODEM: rd_mux = modem_q;
      `A_LSTAT: rd_mux = {1'b0, tx_cnt_q == 6'h00 && tx_idle, tx_cnt_q == 6'h00,
                          2'b00, rx_head[8], 1'b0, rx_any};
      `A_MSTAT: rd_mux = {mstat, 4'h0};
      `A_EFR: rd_mux = efr_q;
      `A_XON: rd_mux = xon_q;
      `A_XOFF: rd_mux = xoff_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      tx_pin_q <= 1'b1;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      general_out_two_n_q <= 1'b1;
      int_out_q <= 1'b0;
      int_oe_n_q <= 1'b1;
    end else begin
      // Read data stands only in the cycle after the strobe
      rdata_q <= rd_en ? rd_mux : 8'h00;
      if (loop) tx_pin_q <= 1'b1;
      else tx_pin_q <= ir_mode ? ~serial_out : serial_out;
      dtr_n_q <= ~modem_q[`MC_DTR];
      // auto flow may hold off sender
      if (efr_q[`EF_ARTS] && ef_en) rts_n_q <= ~modem_q[`MC_RTS] | rx_irq;
      else rts_n_q <= ~modem_q[`MC_RTS];
      general_out_two_n_q <= ~modem_q[`MC_OUT2];
      int_oe_n_q <= ~modem_q[`MC_OUT2];
      int_out_q <= modem_q[`MC_OUT2] && (rx_irq || tx_irq_q);
    end
  end

endmodule // uart_line_format_modem_control
`default_nettype wire

//--- sim/uart_lfmc_chk.sv
`include "uart_lfmc_map.vh"
`default_nettype none
module uart_lfmc_chk (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata_q,
  input wire tx_pin_q,
  input wire rts_n_q,
  input wire dtr_n_q,
  input wire general_out_two_n_q,
  input wire int_out_q,
  input wire int_oe_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] lc_q;
  reg [7:0] mc_q;
  reg [7:0] ef_q;
  reg [1:0] age_q;
  wire calm;
  // ----
  // Shadow registers
  // ----
  // Age gives registered pins time to follow a write before they are judged
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lc_q <= `LINE_RST;
      mc_q <= `MODEM_RST;
      ef_q <= `EFR_RST;
      age_q <= 2'h3;
    end else begin
      if (wr_en && addr == `A_LINE) lc_q <= wdata;
      if (wr_en && addr == `A_MODEM) mc_q <= wdata;
      if (wr_en && addr == `A_EFR) ef_q <= wdata;
      if (wr_en) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
  end
  assign calm = (age_q == 2'h3);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----
  // Properties
  // ----
  // Loopback leaves the modem outputs following the modem register, yet the dtr, rts and out2 pin checks skip it
  property p_dtr; calm && !mc_q[`MC_LOOP] |-> dtr_n_q == ~mc_q[`MC_DTR]; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr_n_q wrong");
  property p_rts;
    calm && !mc_q[`MC_LOOP] && !ef_q[`EF_ARTS] |-> rts_n_q == ~mc_q[`MC_RTS];
  endproperty
  a_rts: assert property (p_rts) else $error("rts_n_q wrong");
  property p_out2;
    calm && !mc_q[`MC_LOOP] |-> general_out_two_n_q == ~mc_q[`MC_OUT2];
  endproperty
  a_out2: assert property (p_out2) else $error("second output wrong");
  property p_ioe; calm |-> int_oe_n_q == ~mc_q[`MC_OUT2]; endproperty
  a_ioe: assert property (p_ioe) else $error("int_oe_n_q wrong");
  property p_ioff; calm && !mc_q[`MC_OUT2] |-> !int_out_q; endproperty
  a_ioff: assert property (p_ioff) else $error("int_out_q while disabled");
  property p_brk; calm && lc_q[`LC_BRK] && !mc_q[`MC_LOOP] |-> !tx_pin_q; endproperty
  a_brk: assert property (p_brk) else $error("tx_pin_q high in break");
  property p_loop; calm && mc_q[`MC_LOOP] && !lc_q[`LC_BRK] |-> tx_pin_q [*2]; endproperty
  a_loop: assert property (p_loop) else $error("tx_pin_q not idle in loopback");
  property p_rdz; !$past(rd_en) |-> rdata_q == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("rdata_q not zero");
  property p_rdl; $past(rd_en && addr == `A_LINE) |-> rdata_q == $past(lc_q); endproperty
  a_rdl: assert property (p_rdl) else $error("line readback wrong");
  property p_rdm;
    $past(rd_en && addr == `A_MODEM) |-> rdata_q[4:0] == $past(mc_q[4:0]);
  endproperty
  a_rdm: assert property (p_rdm) else $error("modem readback wrong");
  property p_unm; $past(rd_en && (addr == 4'h7 || addr > 4'hA)) |-> rdata_q == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // uart_lfmc_chk

bind uart_line_format_modem_control uart_lfmc_chk i_chk (.mclk(mclk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
  .tx_pin_q(tx_pin_q), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q),
  .general_out_two_n_q(general_out_two_n_q), .int_out_q(int_out_q), .int_oe_n_q(int_oe_n_q));
`default_nettype wire

//--- sim/uart_line_format_modem_control_tb.sv
`include "uart_lfmc_map.vh"
`default_nettype none
module uart_line_format_modem_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] d; logic p; int per;} fexp_t;
  logic mclk, rst_n, wr_en, rd_en, rd_d, listen, got, rx_pin;
  logic cts_n, dsr_n, cd_n, ring_indicator_n;
  logic tx_pin_q, rts_n_q, dtr_n_q, general_out_two_n_q, int_out_q, int_oe_n_q;
  logic [3:0] addr, mp;
  logic [7:0] wdata, rdata_q, lc, c, f;
  logic [16:0] word;
  logic [15:0] re;
  logic [15:0] rq[$];
  fexp_t fq[$];
  fexp_t fe;
  logic [7:0] v[28];
  logic [7:0] fm[8] = '{8'h00, 8'h0D, 8'h1A, 8'h2B, 8'h3F, 8'h04, 8'h07, 8'h0B};
  int fails, n_checks, cyc, t, k, n, thr;
  uart_line_format_modem_control i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .rx_pin(rx_pin),
    .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n), .ring_indicator_n(ring_indicator_n),
    .tx_pin_q(tx_pin_q), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q),
    .general_out_two_n_q(general_out_two_n_q), .int_out_q(int_out_q), .int_oe_n_q(int_oe_n_q));
  uart_peer i_peer (.mclk(mclk), .tx_pin_q(tx_pin_q), .fmt(lc), .listen(listen),
    .rx_pin(rx_pin), .got(got), .word(word));
  // ----
  // Compare and bus tasks
  // ----
  task automatic cmp_rd(input logic [15:0] e, input logic [7:0] s);
    n_checks++;
    if ((s & e[15:8]) !== e[7:0]) begin
      fails++;
      $display("[ERR] rdata_q exp %h mask %h seen %h", e[7:0], e[15:8], s);
    end
  endtask
  task automatic cmp_frame(input fexp_t e, input logic [16:0] w);
    n_checks++;
    if (w[8:0] !== {e.p, e.d} || (e.per != 0 && (w[16:9] < e.per || w[16:9] > e.per + 3))) begin
      fails++;
      $display("[ERR] frame exp %h/%0d seen %h/%0d", {e.p, e.d}, e.per, w[8:0], w[16:9]);
    end
  endtask
  task automatic cmp_pin(input logic [5:0] e);
    n_checks++;
    if ({tx_pin_q, dtr_n_q, rts_n_q, general_out_two_n_q, int_oe_n_q, int_out_q} !== e) begin
      fails++;
      $display("[ERR] pins exp %b seen %b", e,
        {tx_pin_q, dtr_n_q, rts_n_q, general_out_two_n_q, int_oe_n_q, int_out_q});
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // The expectation is queued before the strobe so the monitor always finds it
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    rq.push_back({m, e & m});
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
  endtask
  task automatic chk_reset();
    rd(`A_LINE, 8'h00, 8'hFF);
    rd(`A_MODEM, 8'h00, 8'h1F);
    rd(4'h7, 8'h00, 8'hFF);
    wr(4'hC, 8'h5A);
    rd(4'hF, 8'h00, 8'hFF);
    #1 cmp_pin(6'h3E);
    $display("test reset done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // Clock, monitors, watchdog
  // ----
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_d === 1'b1) begin
      re = rq.pop_front();
      cmp_rd(re, rdata_q);
    end
    rd_d <= rd_en;
  end
  always @(posedge got) begin
    fe = fq.pop_front();
    cmp_frame(fe, word);
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      complete_run();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    {addr, wdata, wr_en, rd_en, rd_d, lc} = '0;
    {cts_n, dsr_n, cd_n, ring_indicator_n, listen} = 5'h1F;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(32'h7dd6_d03e));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chk_reset();
    mp = 4'($urandom());
    @(posedge mclk);
    {cd_n, ring_indicator_n, dsr_n, cts_n} <= mp;
    repeat (4) @(posedge mclk);
    rd(`A_MSTAT, {~mp, 4'h0}, 8'hF0);
    for (t = 0; t < 16; t++) begin
      wr(`A_MODEM, 8'(t));
      repeat (3) @(posedge mclk);
      #1 cmp_pin({1'b1, ~t[0], ~t[1], ~t[3], ~t[3], 1'b0});
      rd(`A_MODEM, 8'(t), 8'h1F);
    end
    wr(`A_MODEM, 8'h00);
    $display("test modem outputs done");
    for (k = 0; k < 8; k++) begin
      f = fm[k];
      wr(`A_LINE, f);
      lc = f;
      n = f[1:0] + 5;
      for (t = 0; t < 2; t++) begin
        c = 8'($urandom());
        fe.d = c & ~(8'hFF << n);
        fe.p = f[3] & (f[5] ? ~f[4] : ~(f[4] ^ (^fe.d)));
        fe.per = t * (16 * (1 + n + f[3]) + (f[2] ? ((n == 5) ? 24 : 32) : 16));
        fq.push_back(fe);
        wr(`A_DATA, c);
      end
      while (fq.size() != 0) @(posedge mclk);
      repeat (40) @(posedge mclk);
    end
    $display("test formats done");
    listen = 1'b0;
    wr(`A_LINE, 8'h43);
    repeat (20) @(posedge mclk);
    #1 cmp_pin(6'h1E);
    wr(`A_LINE, 8'h03);
    lc = 8'h03;
    repeat (40) @(posedge mclk);
    #1 cmp_pin(6'h3E);
    listen = 1'b1;
    wr(`A_LINE, 8'h83);
    wr(`A_DATA, 8'h01);
    wr(`A_DIVH, 8'h00);
    rd(`A_DATA, 8'h01, 8'hFF);
    rd(`A_DIVH, 8'h00, 8'hFF);
    wr(`A_LINE, 8'h03);
    rd(`A_DATA, 8'h00, 8'hFF);
    $display("test break and divisor done");
    wr(`A_FIFO, 8'h01);
    wr(`A_LINE, 8'h1B);
    lc = 8'h1B;
    c = 8'($urandom());
    i_peer.send(c, 1'b0);
    i_peer.send(~c, 1'b1);
    rd(`A_LSTAT, 8'h01, 8'h05);
    rd(`A_DATA, c, 8'hFF);
    rd(`A_LSTAT, 8'h05, 8'h05);
    rd(`A_DATA, ~c, 8'hFF);
    // Stop character halts the sender; any other resumes it and, unless it is the start character, is kept
    wr(`A_EFR, 8'h12);
    wr(`A_MODEM, 8'h20);
    i_peer.send(`XOFF_RST, 1'b0);
    rd(`A_FIFO, 8'h08, 8'h08);
    c = 8'($urandom()) | 8'h80;
    i_peer.send(c, 1'b0);
    rd(`A_FIFO, 8'h00, 8'h08);
    rd(`A_DATA, c, 8'hFF);
    wr(`A_EFR, 8'h00);
    $display("test receive done");
    wr(`A_LINE, 8'h03);
    lc = 8'h03;
    listen = 1'b0;
    wr(`A_MODEM, 8'h1C);
    rd(`A_MSTAT, 8'hC0, 8'hF0);
    for (t = 0; t < 4; t++) begin
      thr = (t == 3) ? 28 : 8 * (t + 1);
      wr(`A_FIFO, {t[1:0], 6'h03});
      for (k = 0; k < thr; k++) begin
        v[k] = 8'($urandom());
        wr(`A_DATA, v[k]);
        if (k == thr - 2) begin
          repeat ((thr - 1) * 170) @(posedge mclk);
          rd(`A_FIFO, 8'hC0, 8'hC1);
        end
      end
      repeat (300) @(posedge mclk);
      #1 cmp_pin(6'h39);
      rd(`A_FIFO, 8'hC1, 8'hC1);
      for (k = 0; k < thr; k++) rd(`A_DATA, v[k], 8'hFF);
    end
    $display("test loopback triggers done");
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    lc = 8'h00;
    listen = 1'b1;
    chk_reset();
    repeat (2) @(posedge mclk);
    complete_run();
  end
endmodule // uart_line_format_modem_control_tb
`default_nettype wire

//--- sim/uart_peer.sv
`default_nettype none
module uart_peer (
  input wire logic mclk,
  input wire logic tx_pin_q,
  input wire logic [7:0] fmt,
  input wire logic listen,
  output logic rx_pin,
  output logic got,
  output logic [16:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc;
  int t0;
  int i;
  logic [7:0] d;
  logic p;
  initial begin
    rx_pin = 1'b1;
    got = 1'b0;
    word = 17'h0_0000;
    cyc = 0;
    t0 = 0;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // ----
  // Frame capture
  // ----
  // decode; start-to-start time exposes stop length
  always begin
    @(negedge tx_pin_q);
    if (listen) begin
      word[16:9] = 8'(cyc - t0);
      t0 = cyc;
      d = 8'h00;
      p = 1'b0;
      repeat (8) @(posedge mclk);
      for (i = 0; i < fmt[1:0] + 5; i++) begin
        repeat (16) @(posedge mclk);
        d[i] = tx_pin_q;
      end
      if (fmt[3]) begin
        repeat (16) @(posedge mclk);
        p = tx_pin_q;
      end
      repeat (8) @(posedge mclk);
      word[8:0] = {p, d};
      got = 1'b1;
      @(posedge mclk);
      got = 1'b0;
    end
  end
  // far end frame; bad flips parity to provoke an error
  task automatic send(input logic [7:0] c, input logic bad);
    int k;
    logic q;
    q = fmt[5] ? ~fmt[4] : ~(fmt[4] ^ (^(c & ~(8'hFF << (fmt[1:0] + 5)))));
    @(posedge mclk);
    rx_pin <= 1'b0;
    repeat (16) @(posedge mclk);
    for (k = 0; k < fmt[1:0] + 5; k++) begin
      rx_pin <= c[k];
      repeat (16) @(posedge mclk);
    end
    if (fmt[3]) begin
      rx_pin <= q ^ bad;
      repeat (16) @(posedge mclk);
    end
    rx_pin <= 1'b1;
    repeat (40) @(posedge mclk);
  endtask
endmodule // uart_peer
`default_nettype wire
